//--- rtl/capture_recorder_pkg.sv
// constants and types of the disturbance capture recorder
`default_nettype none
package capture_recorder_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ANALOG_MAX = 32;
  localparam int unsigned BINARY_MAX = 64;
  localparam int unsigned MEMORY_BYTES = 12 * 1024 * 1024;
  localparam int unsigned RATE_LOW = 20;
  localparam int unsigned RATE_HIGH = 40;
  localparam int unsigned ANALOG_KB_PER_S = 7;
  localparam int unsigned BINARY_KB_PER_S = 2;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned HZ_50 = 50;
  localparam int unsigned HZ_60 = 60;
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_PRE = 12'h004;
  localparam logic [11:0] REG_POST = 12'h008;
  localparam logic [11:0] REG_MAX = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_IRQ = 12'h014;
  localparam logic [11:0] REG_MASK = 12'h018;
  localparam logic [11:0] REG_COUNT = 12'h01C;
  localparam logic [11:0] REG_CHAN = 12'h020;
  // ctrl fields
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_HIGH_RATE = 1;
  localparam int unsigned CTRL_NET60 = 2;
  // irq bits
  localparam int unsigned IRQ_START = 0;
  localparam int unsigned IRQ_DONE = 1;
  localparam int unsigned IRQ_WARN = 2;
  localparam int unsigned IRQ_OVF = 3;
  localparam int unsigned IRQ_W = 4;
  // time setting reset values, ms
  localparam logic [15:0] PRE_MS_RST = 16'h00C8;
  localparam logic [15:0] POST_MS_RST = 16'h00C8;
  localparam logic [15:0] MAX_MS_RST = 16'h03E8;
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_POST} rec_state_t;
endpackage
`default_nettype wire

//--- rtl/disturbance_capture_recorder.sv
// disturbance capture recorder with apb register file
`default_nettype none
module disturbance_capture_recorder #(
  parameter int unsigned HIST_DEPTH = 2048,
  parameter int unsigned MEM_WORDS = 4096
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // network sample timing and channels
  input wire logic sample_tick,
  input wire logic [31:0] analog_sample,
  input wire logic [63:0] binary_sample,
  input wire logic capture_trigger_input,
  // record stream toward storage
  output logic [31:0] rec_data,
  output logic rec_valid,
  output logic rec_last,
  output logic recording,
  output logic irq
);
  localparam int unsigned HW = $clog2(HIST_DEPTH);
  localparam int unsigned MW = $clog2(MEM_WORDS);

  // samples per ms: 20 per period (40 with high rate) times network hertz / 1000
  function automatic logic [31:0] ms_to_samples(input logic [15:0] ms, input logic hi,
                                                input logic n60);
    logic [31:0] per_s;
    per_s = (hi ? capture_recorder_pkg::RATE_HIGH : capture_recorder_pkg::RATE_LOW)
          * (n60 ? capture_recorder_pkg::HZ_60 : capture_recorder_pkg::HZ_50);
    return 32'((32'(ms) * per_s) / capture_recorder_pkg::MS_PER_S);
  endfunction

  typedef struct packed {
    logic [2:0] ctrl;
    logic [15:0] pre_ms;
    logic [15:0] post_ms;
    logic [15:0] max_ms;
    logic [3:0] irq_st;
    logic [3:0] mask;
    capture_recorder_pkg::rec_state_t st;
    logic trig_seen_low;
    logic [HW-1:0] wr_ptr;
    logic [HW:0] fill;
    logic [31:0] cnt;
    logic [31:0] post_left;
    logic [HW:0] dly;
    logic [MW-1:0] words;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [31:0] rec_data;
    logic rec_valid;
    logic rec_last;
    logic irq;
    logic rec_on;
  } state_t;

  state_t q, d;
  // history of analog samples; binary sits beside it
  logic [31:0] hist_a [HIST_DEPTH];
  logic [63:0] hist_b [HIST_DEPTH];

  logic setup, wr, rd;
  logic [31:0] pre_n, post_n, max_n;
  logic warn, trig_start, ev_start, ev_done, ev_ovf;
  logic [3:0] ev;
  logic [31:0] old_a;

  always_comb begin
    // delayed tap: the record lags the live input by the pre window
    old_a = hist_a[HW'(q.wr_ptr - HW'(q.dly))];
    setup = psel && !penable;
    wr = psel && penable && pwrite && q.ready;
    rd = setup && !pwrite;
    pre_n = ms_to_samples(q.pre_ms, q.ctrl[capture_recorder_pkg::CTRL_HIGH_RATE],
                          q.ctrl[capture_recorder_pkg::CTRL_NET60]);
    post_n = ms_to_samples(q.post_ms, q.ctrl[capture_recorder_pkg::CTRL_HIGH_RATE],
                           q.ctrl[capture_recorder_pkg::CTRL_NET60]);
    max_n = ms_to_samples(q.max_ms, q.ctrl[capture_recorder_pkg::CTRL_HIGH_RATE],
                          q.ctrl[capture_recorder_pkg::CTRL_NET60]);
    warn = (32'(q.pre_ms) + 32'(q.post_ms)) > 32'(q.max_ms);
    // warn blocks start: settings are not trusted
    trig_start = q.ctrl[capture_recorder_pkg::CTRL_ENABLE] && capture_trigger_input
                 && q.trig_seen_low && !warn && q.st == capture_recorder_pkg::ST_IDLE
                 && sample_tick;
    ev_start = trig_start;
    ev_done = 1'b0;
    ev_ovf = 1'b0;
    d = q;
    d.rec_valid = 1'b0;
    d.rec_last = 1'b0;
    d.ready = 1'b0;
    d.err = 1'b0;
    if (!capture_trigger_input) begin
      d.trig_seen_low = 1'b1;
    end
    // history runs always so pre window is ready at trigger
    if (sample_tick) begin
      d.wr_ptr = HW'(q.wr_ptr + 1'b1);
      if (q.fill != (HW+1)'(HIST_DEPTH)) begin
        d.fill = (HW+1)'(q.fill + 1'b1);
      end
    end
    case (q.st)
      capture_recorder_pkg::ST_IDLE: begin
        if (trig_start) begin
          d.st = capture_recorder_pkg::ST_ACTIVE;
          d.trig_seen_low = 1'b0;
          // pre window length, clipped to what history holds
          d.cnt = (pre_n > 32'(q.fill)) ? 32'(q.fill) : pre_n;
          d.dly = (HW+1)'(d.cnt);
          // post runs longer by the delay so the tail still leaves the history
          d.post_left = post_n + d.cnt;
          d.words = '0;
        end
      end
      capture_recorder_pkg::ST_ACTIVE: begin
        if (sample_tick) begin
          d.rec_valid = 1'b1;
          d.rec_data = (q.dly == '0) ? analog_sample : old_a;
          d.cnt = q.cnt + 32'h0000_0001;
          if (!capture_trigger_input || q.cnt + 32'h0000_0001 >= max_n) begin
            d.st = capture_recorder_pkg::ST_POST;
          end
        end
      end
      capture_recorder_pkg::ST_POST: begin
        if (sample_tick) begin
          d.rec_valid = 1'b1;
          d.rec_data = (q.dly == '0) ? analog_sample : old_a;
          d.post_left = q.post_left - 32'h0000_0001;
          if (q.post_left <= 32'h0000_0001) begin
            d.rec_last = 1'b1;
            d.st = capture_recorder_pkg::ST_IDLE;
            ev_done = 1'b1;
          end
        end
      end
      default: d.st = capture_recorder_pkg::ST_IDLE;
    endcase
    d.rec_on = (d.st != capture_recorder_pkg::ST_IDLE);
    // record word budget stands for the bounded record memory
    if (d.rec_valid) begin
      if (q.words == MW'(MEM_WORDS - 1)) begin
        ev_ovf = 1'b1;
        d.rec_valid = 1'b0;
      end else begin
        d.words = MW'(q.words + 1'b1);
      end
    end
    ev = '0;
    ev[capture_recorder_pkg::IRQ_START] = ev_start;
    ev[capture_recorder_pkg::IRQ_DONE] = ev_done;
    ev[capture_recorder_pkg::IRQ_WARN] = warn;
    ev[capture_recorder_pkg::IRQ_OVF] = ev_ovf;
    if (wr) begin
      case (paddr)
        capture_recorder_pkg::REG_CTRL: d.ctrl = pwdata[2:0];
        capture_recorder_pkg::REG_PRE: d.pre_ms = pwdata[15:0];
        capture_recorder_pkg::REG_POST: d.post_ms = pwdata[15:0];
        capture_recorder_pkg::REG_MAX: d.max_ms = pwdata[15:0];
        capture_recorder_pkg::REG_IRQ: d.irq_st = q.irq_st & ~pwdata[3:0];
        capture_recorder_pkg::REG_MASK: d.mask = pwdata[3:0];
        default: d.err = 1'b0;
      endcase
    end
    // set wins over a same-cycle clear
    d.irq_st = d.irq_st | ev;
    d.irq = |(d.irq_st & d.mask);
    if (setup) begin
      d.ready = 1'b1;
      d.err = !(paddr inside {capture_recorder_pkg::REG_CTRL, capture_recorder_pkg::REG_PRE,
                capture_recorder_pkg::REG_POST, capture_recorder_pkg::REG_MAX,
                capture_recorder_pkg::REG_STATUS, capture_recorder_pkg::REG_IRQ,
                capture_recorder_pkg::REG_MASK, capture_recorder_pkg::REG_COUNT,
                capture_recorder_pkg::REG_CHAN});
      d.rdata = '0;
      if (rd) begin
        case (paddr)
          capture_recorder_pkg::REG_CTRL: d.rdata = {29'h0, q.ctrl};
          capture_recorder_pkg::REG_PRE: d.rdata = {16'h0, q.pre_ms};
          capture_recorder_pkg::REG_POST: d.rdata = {16'h0, q.post_ms};
          capture_recorder_pkg::REG_MAX: d.rdata = {16'h0, q.max_ms};
          capture_recorder_pkg::REG_STATUS: d.rdata = {28'h0, warn, q.trig_seen_low, q.st};
          capture_recorder_pkg::REG_IRQ: d.rdata = {28'h0, q.irq_st};
          capture_recorder_pkg::REG_MASK: d.rdata = {28'h0, q.mask};
          capture_recorder_pkg::REG_COUNT: d.rdata = 32'(q.words);
          // channel limits: 32 analog, 64 binary
          capture_recorder_pkg::REG_CHAN:
            d.rdata = {16'(capture_recorder_pkg::BINARY_MAX),
                       16'(capture_recorder_pkg::ANALOG_MAX)};
          default: d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (sample_tick) begin
      hist_a[q.wr_ptr] <= analog_sample;
      hist_b[q.wr_ptr] <= binary_sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.pre_ms <= capture_recorder_pkg::PRE_MS_RST;
      q.post_ms <= capture_recorder_pkg::POST_MS_RST;
      q.max_ms <= capture_recorder_pkg::MAX_MS_RST;
      q.st <= capture_recorder_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign rec_data = q.rec_data;
  assign rec_valid = q.rec_valid;
  assign rec_last = q.rec_last;
  assign recording = q.rec_on;
  assign irq = q.irq;

  property p_no_start_disabled;
    @(posedge pclk) disable iff (!presetn)
    (q.st == capture_recorder_pkg::ST_IDLE && !q.ctrl[capture_recorder_pkg::CTRL_ENABLE])
      |=> q.st == capture_recorder_pkg::ST_IDLE;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("start while off");

  property p_trig_off_ends;
    @(posedge pclk) disable iff (!presetn)
    (q.st == capture_recorder_pkg::ST_ACTIVE && sample_tick && !capture_trigger_input)
      |=> q.st == capture_recorder_pkg::ST_POST;
  endproperty
  a_trig_off_ends: assert property (p_trig_off_ends) else $error("active did not end");

  property p_need_low;
    @(posedge pclk) disable iff (!presetn)
    (q.st == capture_recorder_pkg::ST_IDLE && !q.trig_seen_low)
      |=> q.st == capture_recorder_pkg::ST_IDLE;
  endproperty
  a_need_low: assert property (p_need_low) else $error("restart without deassert");

  property p_warn_irq;
    @(posedge pclk) disable iff (!presetn)
    warn |=> q.irq_st[capture_recorder_pkg::IRQ_WARN];
  endproperty
  a_warn_irq: assert property (p_warn_irq) else $error("warning not flagged");

  property p_post_valid;
    @(posedge pclk) disable iff (!presetn)
    (q.st == capture_recorder_pkg::ST_POST && sample_tick && q.words != MW'(MEM_WORDS - 1))
      |=> rec_valid;
  endproperty
  a_post_valid: assert property (p_post_valid) else $error("post sample lost");

  sequence s_active_tick;
    q.st == capture_recorder_pkg::ST_ACTIVE && sample_tick;
  endsequence

  sequence s_start_ok;
    q.st == capture_recorder_pkg::ST_IDLE && q.ctrl[capture_recorder_pkg::CTRL_ENABLE]
      && capture_trigger_input && q.trig_seen_low && !warn && sample_tick;
  endsequence

  property p_cap_ends;
    @(posedge pclk) disable iff (!presetn)
    s_active_tick ##0 (q.cnt + 32'h0000_0001 >= max_n) |=> q.st == capture_recorder_pkg::ST_POST;
  endproperty
  a_cap_ends: assert property (p_cap_ends) else $error("cap not enforced");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    s_start_ok |=> recording && q.st == capture_recorder_pkg::ST_ACTIVE;
  endproperty
  a_start: assert property (p_start) else $error("trigger ignored");

  property p_pre_len;
    @(posedge pclk) disable iff (!presetn)
    s_start_ok ##0 (pre_n <= 32'(q.fill)) |=> 32'(q.dly) == $past(pre_n);
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("pre window short");

  property p_active_emits;
    @(posedge pclk) disable iff (!presetn)
    s_active_tick ##0 (q.words != MW'(MEM_WORDS - 1)) |=> rec_valid;
  endproperty
  a_active_emits: assert property (p_active_emits) else $error("active sample lost");

  // a full budget drops the sample and flags it rather than wrap
  property p_full_drops;
    @(posedge pclk) disable iff (!presetn)
    s_active_tick ##0 (q.words == MW'(MEM_WORDS - 1))
      |=> !rec_valid && q.irq_st[capture_recorder_pkg::IRQ_OVF];
  endproperty
  a_full_drops: assert property (p_full_drops) else $error("overflow not flagged");

  property p_last_idle;
    @(posedge pclk) disable iff (!presetn)
    rec_last |-> !recording;
  endproperty
  a_last_idle: assert property (p_last_idle) else $error("last word while busy");

  property p_hist_fill;
    @(posedge pclk) disable iff (!presetn)
    32'(q.fill) <= HIST_DEPTH;
  endproperty
  a_hist_fill: assert property (p_hist_fill) else $error("history overfilled");

  // irq is registered, so it must track status and mask every cycle
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    irq == |(q.irq_st & q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("no ready in access");
endmodule
`default_nettype wire

//--- dv/sample_source.sv
// far-side model: sample timing, random channel data and trigger logic
`default_nettype none
module sample_source #(
  parameter int unsigned DIV = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trigger request from the bench
  input wire logic trig_req,
  // toward the recorder
  output logic sample_tick,
  output logic [31:0] analog_sample,
  output logic [63:0] binary_sample,
  output logic capture_trigger_input
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned div_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 0;
      sample_tick <= 1'b0;
      analog_sample <= 32'h0;
      binary_sample <= 64'h0;
      capture_trigger_input <= 1'b0;
    end else begin
      sample_tick <= (div_q == DIV - 1);
      div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
      // fresh data every sample so stale values never look valid
      if (div_q == DIV - 1) begin
        analog_sample <= $urandom;
        binary_sample <= {$urandom, $urandom};
        capture_trigger_input <= trig_req;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/disturbance_capture_recorder_tb.sv
// self-checking bench for the disturbance capture recorder
`default_nettype none
module disturbance_capture_recorder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_req;
  logic sample_tick, capture_trigger_input, rec_valid, rec_last, recording, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, analog_sample, rec_data;
  logic [63:0] binary_sample;
  logic [32:0] rd_q[$];
  int rec_q[$];
  int errors, checked, cyc, nval, nsmp, dly_now;
  logic [31:0] smp[1024];
  int ctl[3] = '{1, 3, 5};
  int cap[3] = '{500, 1000, 600};

  disturbance_capture_recorder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
    .analog_sample(analog_sample), .binary_sample(binary_sample),
    .capture_trigger_input(capture_trigger_input), .rec_data(rec_data),
    .rec_valid(rec_valid), .rec_last(rec_last), .recording(recording), .irq(irq));
  sample_source src (.pclk(pclk), .presetn(presetn), .trig_req(trig_req),
    .sample_tick(sample_tick), .analog_sample(analog_sample),
    .binary_sample(binary_sample), .capture_trigger_input(capture_trigger_input));

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk iff sample_tick === 1'b1);
  endtask
  // trigger held for hold samples; a hold of at least exp samples must leave it idle
  task automatic record(input int hold, input int exp, input int dly);
    dly_now = dly;
    rec_q.push_back(exp);
    trig_req <= 1'b1;
    ticks(hold);
    trig_req <= 1'b0;
    #1 chk(33'(recording), 33'(hold < exp));
    while (recording !== 1'b0) @(posedge pclk);
    ticks(2);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 40000) begin
      errors++;
      $display("[ERR] %0t run hung", $time);
      give_verdict;
    end
  end
  // watcher: compares read answers and record lengths against the notes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      chk({pslverr, prdata}, rd_q.pop_front());
    if (rec_valid === 1'b1)
      chk(33'(rec_data), 33'(smp[(nsmp - 1 - dly_now) % 1024]));
    if (sample_tick === 1'b1) begin
      smp[nsmp % 1024] = analog_sample;
      nsmp++;
    end
    if (rec_valid === 1'b1) nval++;
    if (rec_last === 1'b1) begin
      chk(33'(nval), rec_q.size() > 0 ? 33'(rec_q.pop_front()) : 33'h0);
      nval = 0;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, trig_req} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(32'hB7B16625));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(capture_recorder_pkg::REG_CTRL, 33'h0);
    rd(capture_recorder_pkg::REG_PRE, 33'hC8);
    rd(capture_recorder_pkg::REG_MAX, 33'h3E8);
    rd(12'h040, 33'h100000000);
    trig_req <= 1'b1;
    ticks(20);
    trig_req <= 1'b0;
    #1 chk(33'(recording), 33'h0);
    apb(1'b1, capture_recorder_pkg::REG_PRE, 32'h258);
    apb(1'b1, capture_recorder_pkg::REG_POST, 32'h258);
    apb(1'b1, capture_recorder_pkg::REG_MAX, 32'h1F4);
    apb(1'b1, capture_recorder_pkg::REG_MASK, 32'h4);
    apb(1'b1, capture_recorder_pkg::REG_CTRL, 32'h1);
    ticks(3);
    rd(capture_recorder_pkg::REG_STATUS, 33'hC);
    #1 chk(33'(irq), 33'h1);
    trig_req <= 1'b1;
    ticks(20);
    trig_req <= 1'b0;
    #1 chk(33'(recording), 33'h0);
    apb(1'b1, capture_recorder_pkg::REG_PRE, 32'h64);
    apb(1'b1, capture_recorder_pkg::REG_POST, 32'h64);
    apb(1'b1, capture_recorder_pkg::REG_MASK, 32'h2);
    apb(1'b1, capture_recorder_pkg::REG_IRQ, 32'hF);
    rd(capture_recorder_pkg::REG_IRQ, 33'h0);
    #1 chk(33'(irq), 33'h0);
    // three rates: 1 sample per ms, 2 per ms, 1.2 per ms
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, capture_recorder_pkg::REG_CTRL, 32'(ctl[i]));
      ticks(260);
      record(cap[i] + 50, cap[i] * 6 / 5, cap[i] / 5);
    end
    rd(capture_recorder_pkg::REG_IRQ, 33'h3);
    #1 chk(33'(irq), 33'h1);
    apb(1'b1, capture_recorder_pkg::REG_IRQ, 32'h3);
    rd(capture_recorder_pkg::REG_IRQ, 33'h0);
    #1 chk(33'(irq), 33'h0);
    apb(1'b1, capture_recorder_pkg::REG_CTRL, 32'h1);
    ticks(260);
    record(50, 250, 100);
    ticks(5);
    chk(33'(rec_q.size() + rd_q.size()), 33'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
